// ==== hw/hobd_cfg_if.sv ====
// Interface: stored option bytes and local power sense to power decision logic, power state back
`timescale 1ns/10ps
interface hobd_cfg_if;
    logic [7:0] primary;
    logic [7:0] secondary;
    logic local_power;
    logic self_powered;
    modport src (output primary, output secondary, output local_power, input self_powered);
    modport dst (input primary, input secondary, input local_power, output self_powered);
endinterface : hobd_cfg_if

// ==== hw/hobd_pkg.sv ====
// Package: offsets, field positions, defaults and timer counts of the option decoder
package hobd_pkg;
    // ************************************************************
    // Configuration byte offsets
    // ************************************************************
    localparam logic [3:0] OFS_PRIMARY = 4'h6;
    localparam logic [3:0] OFS_SECONDARY = 4'h7;
    localparam logic [3:0] OFS_FIXED_MAP = 4'h8;
    localparam logic [3:0] OFS_SP_OFF = 4'h9;
    localparam logic [3:0] OFS_BP_OFF = 4'ha;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int B_PWR_SRC = 7;
    localparam int B_LED = 6;
    localparam int B_FAST_OFF = 5;
    localparam int B_TT = 4;
    localparam int B_EOP_OFF = 3;
    localparam int B_SNS_HI = 2;
    localparam int B_SNS_LO = 1;
    localparam int B_SWITCH = 0;
    localparam int B_DYNAMIC = 7;
    localparam int B_DLY_HI = 5;
    localparam int B_DLY_LO = 4;
    localparam int B_COMPOUND = 3;
    // Only ports 1..3 are real; everything else in a port byte is reserved
    localparam logic [7:0] PORT_MASK = 8'h0e;
    localparam logic [7:0] SEC_MASK = 8'hb8;
    // ************************************************************
    // Reset values (self-powered default set)
    // ************************************************************
    localparam logic [7:0] RST_PRIMARY = 8'h98;
    localparam logic [7:0] RST_SECONDARY = 8'h90;
    localparam logic [7:0] RST_PORT = 8'h00;
    // ************************************************************
    // Over-current delay: times in microseconds at 50 MHz
    // ************************************************************
    localparam int CLK_MHZ = 50;
    localparam int DLY0_US = 100;
    localparam int DLY1_US = 2000;
    localparam int DLY2_US = 4000;
    localparam int DLY3_US = 6000;
    localparam int DLY0_CYC = DLY0_US * CLK_MHZ;
    localparam int DLY1_CYC = DLY1_US * CLK_MHZ;
    localparam int DLY2_CYC = DLY2_US * CLK_MHZ;
    localparam int DLY3_CYC = DLY3_US * CLK_MHZ;
    localparam int DLY_W = 19;
endpackage : hobd_pkg

// ==== hw/hobd_power_sel.sv ====
// Power source decision: option bit or local power sense under dynamic switching
`timescale 1ns/10ps
module hobd_power_sel (
    hobd_cfg_if.dst cfg // Option bytes in, power state out
);
    wire dyn_en = cfg.secondary[hobd_pkg::B_DYNAMIC];
    // Under dynamic switching the sense pin overrides the option bit
    assign cfg.self_powered = dyn_en ? cfg.local_power
                                     : cfg.primary[hobd_pkg::B_PWR_SRC];
endmodule : hobd_power_sel

// ==== hw/hub_option_byte_decoder.sv ====
// Hub option byte decoder: loads option bytes 6..A and drives hub core controls
// What this block does
// - Primary bit 7 selects bus (0) or self (1) power.
// - With dynamic switching on, local power sense decides power mode.
// - Primary bit 6 reports indicator LEDs present.
// - Primary bit 5 set forces full-speed only attachment.
// - Primary bit 4 selects shared or per-port translators.
// - Primary bit 3 clear enables end-of-frame EOP; set suppresses it.
// - Primary bits 2:1 set ganged, per-port or no over-current sensing.
// - Primary bit 0 selects ganged or per-port power switching.
// - Secondary bit 7 enables fallback to bus power and return.
// - Secondary bits 5:4 pick over-current delay 0.1, 2, 4, 6 ms.
// - Secondary bit 3 flags compound device.
// - Fixed port map bits 1..3 mark non-removable ports; others zero.
// - Self-powered mask bits 1..3 disable ports; others read zero.
// - Fixed port map applies only for a compound device.
// - Configuration is loaded before attaching upstream.
// - Bus-powered mask disables ports in bus-powered operation.
`timescale 1ns/10ps
module hub_option_byte_decoder (
    input wire logic i_clk, // 50 MHz system clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic i_cfg_we, // Byte write strobe from loader
    input wire logic [3:0] i_cfg_addr, // Configuration byte offset
    input wire logic [7:0] i_cfg_wdata, // Byte written
    input wire logic i_cfg_done, // Loader finished all bytes
    input wire logic i_local_power_sense_pin, // Local supply present
    input wire logic i_overload_raw, // Raw over-current event, any port
    output logic [7:0] o_cfg_rdata, // Read data for i_cfg_addr
    output logic o_attach_en, // Allowed to attach upstream
    output logic o_self_powered, // Current power state
    output logic o_indicator_led_present, // LED indicators fitted
    output logic o_fast_mode_off, // Full-speed only
    output logic o_per_port_translator_en, // One translator per port
    output logic o_frame_end_packet_off, // EOP at EOF1 suppressed
    output logic [1:0] o_overload_sense_mode, // 00 ganged, 01 per port, 1x none
    output logic o_port_switch_mode, // 1 per-port power switching
    output logic o_compound, // Part of compound device
    output logic [3:1] o_fixed_ports, // Non-removable ports in effect
    output logic [3:1] o_port_off, // Ports disabled for current power mode
    output logic o_overload_flag // Over-current persisted for the delay
);
    // ************************************************************
    // Option byte storage
    // ************************************************************
    logic [7:0] prim_q;
    logic [7:0] sec_q;
    logic [7:0] fixed_port_map_q;
    logic [7:0] self_power_port_off_mask_q;
    logic [7:0] bus_power_port_off_mask_q;
    logic loaded_q;

    // ************************************************************
    // Write decode
    // ************************************************************
    wire wr_prim = i_cfg_we && (i_cfg_addr == hobd_pkg::OFS_PRIMARY);
    wire wr_sec = i_cfg_we && (i_cfg_addr == hobd_pkg::OFS_SECONDARY);
    wire wr_fix = i_cfg_we && (i_cfg_addr == hobd_pkg::OFS_FIXED_MAP);
    wire wr_sp = i_cfg_we && (i_cfg_addr == hobd_pkg::OFS_SP_OFF);
    wire wr_bp = i_cfg_we && (i_cfg_addr == hobd_pkg::OFS_BP_OFF);
    // Reserved positions are dropped on write so they can never steer anything
    wire [7:0] sec_w = i_cfg_wdata & hobd_pkg::SEC_MASK;
    wire [7:0] port_w = i_cfg_wdata & hobd_pkg::PORT_MASK;

    // Primary byte has no reserved bits, so it is kept whole
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) prim_q <= hobd_pkg::RST_PRIMARY;
        else if (wr_prim) prim_q <= i_cfg_wdata;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) sec_q <= hobd_pkg::RST_SECONDARY;
        else if (wr_sec) sec_q <= sec_w;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) fixed_port_map_q <= hobd_pkg::RST_PORT;
        else if (wr_fix) fixed_port_map_q <= port_w;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) self_power_port_off_mask_q <= hobd_pkg::RST_PORT;
        else if (wr_sp) self_power_port_off_mask_q <= port_w;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) bus_power_port_off_mask_q <= hobd_pkg::RST_PORT;
        else if (wr_bp) bus_power_port_off_mask_q <= port_w;
    end

    // Attach only once the loader has delivered the bytes; held until reset
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) loaded_q <= 1'b0;
        else if (i_cfg_done) loaded_q <= 1'b1;
    end

    // ************************************************************
    // Read-back
    // ************************************************************
    logic [7:0] rd_mux;
    always_comb begin
        if (i_cfg_addr == hobd_pkg::OFS_PRIMARY) rd_mux = prim_q;
        else if (i_cfg_addr == hobd_pkg::OFS_SECONDARY) rd_mux = sec_q;
        else if (i_cfg_addr == hobd_pkg::OFS_FIXED_MAP) rd_mux = fixed_port_map_q;
        else if (i_cfg_addr == hobd_pkg::OFS_SP_OFF) rd_mux = self_power_port_off_mask_q;
        else if (i_cfg_addr == hobd_pkg::OFS_BP_OFF) rd_mux = bus_power_port_off_mask_q;
        else rd_mux = 8'h00;
    end

    // ************************************************************
    // Power mode decision
    // ************************************************************
    hobd_cfg_if cfg_bus ();
    assign cfg_bus.primary = prim_q;
    assign cfg_bus.secondary = sec_q;
    assign cfg_bus.local_power = i_local_power_sense_pin;
    hobd_power_sel u_power_sel (
        .cfg(cfg_bus)
    );
    wire self_mode = cfg_bus.self_powered;

    // ************************************************************
    // Over-current delay timer
    // ************************************************************
    function automatic logic [hobd_pkg::DLY_W-1:0] dly_cycles(input logic [1:0] sel);
        case (sel)
            2'b00: dly_cycles = hobd_pkg::DLY_W'(hobd_pkg::DLY0_CYC);
            2'b01: dly_cycles = hobd_pkg::DLY_W'(hobd_pkg::DLY1_CYC);
            2'b10: dly_cycles = hobd_pkg::DLY_W'(hobd_pkg::DLY2_CYC);
            default: dly_cycles = hobd_pkg::DLY_W'(hobd_pkg::DLY3_CYC);
        endcase
    endfunction : dly_cycles

    wire [1:0] overload_delay_sel = sec_q[hobd_pkg::B_DLY_HI:hobd_pkg::B_DLY_LO];
    // Code 1x with self power is not refused here; keeping it legal is the source's duty
    wire sense_off = prim_q[hobd_pkg::B_SNS_HI];
    wire [hobd_pkg::DLY_W-1:0] dly_lim = dly_cycles(overload_delay_sel);
    logic [hobd_pkg::DLY_W-1:0] oc_cnt_q;
    logic [hobd_pkg::DLY_W-1:0] oc_cnt_d;
    // Event must persist the full delay; any gap restarts the count
    wire oc_active = i_overload_raw && !sense_off;
    // Count saturates at the limit so the flag stays up for as long as the fault lasts
    assign oc_cnt_d = !oc_active ? '0
                    : (oc_cnt_q == dly_lim) ? oc_cnt_q
                    : oc_cnt_q + 1'b1;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) oc_cnt_q <= '0;
        else oc_cnt_q <= oc_cnt_d;
    end

    // ************************************************************
    // Decoded controls
    // ************************************************************
    wire compound = sec_q[hobd_pkg::B_COMPOUND];
    wire [3:1] fixed_d = compound ? fixed_port_map_q[3:1] : 3'h0;
    wire [3:1] off_d = self_mode ? self_power_port_off_mask_q[3:1]
                                : bus_power_port_off_mask_q[3:1];

    // ************************************************************
    // Registered outputs: read-back and attach
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) o_cfg_rdata <= 8'h00;
        else o_cfg_rdata <= rd_mux;
    end

    // Attach trails the load by one edge so every decoded control has settled first
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) o_attach_en <= 1'b0;
        else o_attach_en <= loaded_q;
    end

    // ************************************************************
    // Registered outputs: power state and port maps
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_self_powered <= 1'b0;
            o_compound <= 1'b0;
        end else begin
            o_self_powered <= self_mode;
            o_compound <= compound;
        end
    end

    // Port maps follow the power state on the same edge, so the two never disagree
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_fixed_ports <= 3'h0;
            o_port_off <= 3'h0;
        end else begin
            o_fixed_ports <= fixed_d;
            o_port_off <= off_d;
        end
    end

    // ************************************************************
    // Registered outputs: primary option bits
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_indicator_led_present <= 1'b0;
            o_fast_mode_off <= 1'b0;
            o_per_port_translator_en <= 1'b0;
            o_frame_end_packet_off <= 1'b0;
            o_overload_sense_mode <= 2'h0;
            o_port_switch_mode <= 1'b0;
        end else begin
            o_indicator_led_present <= prim_q[hobd_pkg::B_LED];
            o_fast_mode_off <= prim_q[hobd_pkg::B_FAST_OFF];
            o_per_port_translator_en <= prim_q[hobd_pkg::B_TT];
            o_frame_end_packet_off <= prim_q[hobd_pkg::B_EOP_OFF];
            o_overload_sense_mode <= prim_q[hobd_pkg::B_SNS_HI:hobd_pkg::B_SNS_LO];
            o_port_switch_mode <= prim_q[hobd_pkg::B_SWITCH];
        end
    end

    // ************************************************************
    // Registered outputs: over-current flag
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) o_overload_flag <= 1'b0;
        else o_overload_flag <= oc_active && (oc_cnt_q == dly_lim);
    end
endmodule : hub_option_byte_decoder

// ==== tb/hobd_assertions.sv ====
// Checker: port-level properties of the hub option byte decoder
`timescale 1ns/10ps
module hobd_checker (
    input wire logic i_clk, // Clock
    input wire logic i_arst_n, // Reset, active low
    input wire logic i_cfg_we, // Write strobe
    input wire logic [3:0] i_cfg_addr, // Offset
    input wire logic [7:0] i_cfg_wdata, // Write data
    input wire logic i_cfg_done, // Load done
    input wire logic i_local_power_sense_pin, // Local supply
    input wire logic i_overload_raw, // Raw fault
    input wire logic o_attach_en, // Attach allowed
    input wire logic o_self_powered, // Power state
    input wire logic o_indicator_led_present, // LEDs
    input wire logic o_fast_mode_off, // Full speed only
    input wire logic o_per_port_translator_en, // Translators
    input wire logic o_frame_end_packet_off, // EOP off
    input wire logic [1:0] o_overload_sense_mode, // Sense mode
    input wire logic o_port_switch_mode, // Switch mode
    input wire logic o_compound, // Compound
    input wire logic [3:1] o_fixed_ports, // Fixed ports
    input wire logic [3:1] o_port_off, // Disabled ports
    input wire logic o_overload_flag // Fault flag
);
    localparam int dly_cyc [4] = '{hobd_pkg::DLY0_CYC, hobd_pkg::DLY1_CYC, hobd_pkg::DLY2_CYC,
        hobd_pkg::DLY3_CYC};
    logic [7:0] b_q [6:10];
    logic seen_q;
    int ov_q;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    // Shadow of stored bytes, so steady outputs are judged without modelling latency
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            b_q <= '{hobd_pkg::RST_PRIMARY, hobd_pkg::RST_SECONDARY, 8'h00, 8'h00, 8'h00};
            seen_q <= 1'b0;
            ov_q <= 0;
        end else begin
            if (i_cfg_we && i_cfg_addr inside {[4'h6:4'ha]}) begin
                b_q[i_cfg_addr] <= i_cfg_wdata;
            end
            seen_q <= seen_q | i_cfg_done;
            ov_q <= i_overload_raw ? ov_q + 1 : 0;
        end
    end
    chk_option_bits: assert property (
        i_cfg_we && i_cfg_addr == 4'h6 |-> ##2 {o_indicator_led_present, o_fast_mode_off,
        o_per_port_translator_en, o_frame_end_packet_off, o_overload_sense_mode,
        o_port_switch_mode} == $past(i_cfg_wdata[6:0], 2)) else $error("option bits");
    chk_compound_bit: assert property (
        i_cfg_we && i_cfg_addr == 4'h7 |-> ##2 o_compound == $past(i_cfg_wdata[3], 2))
        else $error("compound flag");
    chk_power_state: assert property (
        (!i_cfg_we && $stable(i_local_power_sense_pin)) [*4] |->
        o_self_powered == (b_q[7][7] ? i_local_power_sense_pin : b_q[6][7]))
        else $error("power state");
    chk_fixed_map: assert property (
        (!i_cfg_we) [*3] |-> o_fixed_ports == (b_q[7][3] ? b_q[8][3:1] : 3'h0))
        else $error("fixed ports");
    chk_port_off: assert property (
        (!i_cfg_we && $stable(o_self_powered)) [*4] |->
        o_port_off == (o_self_powered ? b_q[9][3:1] : b_q[10][3:1])) else $error("port off");
    chk_attach_gate: assert property (o_attach_en |-> seen_q) else $error("early attach");
    chk_attach_rise: assert property (
        i_cfg_done |-> ##[1:3] o_attach_en) else $error("no attach");
    chk_overload_early: assert property (
        $rose(o_overload_flag) |-> ov_q >= dly_cyc[b_q[7][5:4]] && !b_q[6][2])
        else $error("flag early");
    chk_overload_late: assert property (
        ov_q == dly_cyc[b_q[7][5:4]] + 3 |-> o_overload_flag || b_q[6][2])
        else $error("flag late");
    chk_overload_drop: assert property (
        !i_overload_raw |=> !o_overload_flag) else $error("flag held");
endmodule : hobd_checker
bind hub_option_byte_decoder hobd_checker CHK (.*);

// ==== tb/hobd_cfg_src.sv ====
// Model of the configuration source that writes option bytes and ends the load
`timescale 1ns/10ps
module hobd_cfg_src (
    input wire logic i_clk, // Clock
    output logic o_we, // Write strobe
    output logic [3:0] o_addr, // Offset
    output logic [7:0] o_wdata, // Data
    output logic o_done // Load finished
);
    initial begin
        o_we = 1'b0;
        o_addr = 4'h0;
        o_wdata = 8'h00;
        o_done = 1'b0;
    end
    task automatic put(input logic [3:0] a, input logic [7:0] d, output logic [7:0] sent);
        // No-sensing code is only legal with bus power selected
        sent = (a == 4'h6 && d[7] && d[2]) ? d & 8'hfb : d;
        @(posedge i_clk);
        o_we <= 1'b1;
        o_addr <= a;
        o_wdata <= sent;
        @(posedge i_clk);
        o_we <= 1'b0;
        o_wdata <= ~sent;
    endtask : put
    task automatic finish();
        @(posedge i_clk);
        o_done <= 1'b1;
        @(posedge i_clk);
        o_done <= 1'b0;
    endtask : finish
endmodule : hobd_cfg_src

// ==== tb/test_hub_option_byte_decoder.sv ====
// Testbench: random option bytes, load completion and over-current delay
`timescale 1ns/10ps
module test_hub_option_byte_decoder;
    logic i_clk = 1'b0, i_arst_n = 1'b0, pin = 1'b1, raw = 1'b0, look = 1'b0, att = 1'b0;
    logic flg, we, done;
    logic [3:0] addr, a;
    logic [7:0] wdata, d;
    logic [7:0] m [16];
    logic [24:0] q [$];
    logic [24:0] exp_v;
    wire [24:0] obs;
    int bad_count = 0, checks = 0, cyc = 0;
    always #10 i_clk = ~i_clk;
    hobd_cfg_src SRC (.i_clk(i_clk), .o_we(we), .o_addr(addr), .o_wdata(wdata), .o_done(done));
    hub_option_byte_decoder DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cfg_we(we),
        .i_cfg_addr(addr), .i_cfg_wdata(wdata), .i_cfg_done(done),
        .i_local_power_sense_pin(pin), .i_overload_raw(raw), .o_cfg_rdata(obs[24:17]),
        .o_attach_en(obs[16]), .o_self_powered(obs[15]), .o_indicator_led_present(obs[14]),
        .o_fast_mode_off(obs[13]), .o_per_port_translator_en(obs[12]),
        .o_frame_end_packet_off(obs[11]), .o_overload_sense_mode(obs[10:9]),
        .o_port_switch_mode(obs[8]), .o_compound(obs[7]), .o_fixed_ports(obs[6:4]),
        .o_port_off(obs[3:1]), .o_overload_flag(obs[0]));
    function automatic logic [24:0] expv();
        logic sp;
        sp = m[7][7] ? pin : m[6][7];
        expv = {m[addr], att, sp, m[6][6:0], m[7][3], m[7][3] ? m[8][3:1] : 3'h0,
            sp ? m[9][3:1] : m[10][3:1], flg};
    endfunction : expv
    // Settle time covers the store edge plus the decode edge
    task automatic chk();
        q.push_back(expv());
        repeat (3) @(posedge i_clk);
        look <= 1'b1;
        @(posedge i_clk);
        look <= 1'b0;
    endtask : chk
    task automatic close_out();
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    always @(posedge i_clk) begin
        cyc++;
        if (look) begin
            exp_v = q.pop_front();
            checks++;
            if (obs !== exp_v) begin
                bad_count++;
                $display("ERROR %0t outputs %h expected %h", $time, obs, exp_v);
            end
        end
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        flg = 1'b0;
        void'($urandom(32'h93e8));
        foreach (m[i]) m[i] = 8'h00;
        m[6] = hobd_pkg::RST_PRIMARY;
        m[7] = hobd_pkg::RST_SECONDARY;
        repeat (10) @(posedge i_clk);
        i_arst_n <= 1'b1;
        chk();
        repeat (60) begin
            a = 4'($urandom_range(15));
            pin <= 1'($urandom);
            SRC.put(a, 8'($urandom), d);
            if (a inside {[4'h6:4'ha]}) begin
                m[a] = d & (a == 4'h6 ? 8'hff : a == 4'h7 ? hobd_pkg::SEC_MASK : hobd_pkg::PORT_MASK);
            end
            chk();
        end
        SRC.finish();
        att = 1'b1;
        chk();
        SRC.put(4'h6, 8'h80, m[6]);
        SRC.put(4'h7, 8'h00, m[7]);
        raw <= 1'b1;
        repeat (hobd_pkg::DLY0_CYC - 10) @(posedge i_clk);
        chk();
        repeat (20) @(posedge i_clk);
        flg = 1'b1;
        chk();
        raw <= 1'b0;
        flg = 1'b0;
        chk();
        close_out();
    end
endmodule : test_hub_option_byte_decoder
